// ===== design/cmt_timer.sv
/*
 * Two-channel compare match timer with an Avalon-MM slave front end,
 * shared start register and a masked, sticky interrupt collector.
 * Assumes a word-addressed Avalon-MM master and a single 100 MHz clock.
 */
// Contract
// - Match flag bit 7 sets when counter equals its constant.
// - Flag clears only by writing 0 after reading 1; reset clears it.
// - Writing 1 to the match flag does nothing.
// - Bit 6 enables the match interrupt request; reset disables it.
// - Bits 1:0 pick counter clock divide 8, 32, 128 or 512.
// - Each channel has a 16-bit read/write up counter resetting to zero.
// - Each channel has a 16-bit read/write constant resetting to all ones.
// - Counters run only while their start bit is set; both reset halted.
`timescale 1ns/1ps
module cmt_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic match_interrupt_ch0,
    output logic match_interrupt_ch1,
    output logic irq
);
    logic [cmt_pkg::CMT_DIV_SELECTS-1:0] ticks;
    logic ack, next_ack;
    logic [31:0] readdata, next_readdata;
    logic [1:0] run, next_run;
    logic [1:0] irq_status, next_irq_status;
    logic [1:0] irq_mask, next_irq_mask;
    logic wr_go;
    logic rd_go;

    cmt_chan_if ch0 ();
    cmt_chan_if ch1 ();

    cmt_prescaler u_prescaler (
        .clk(clk),
        .rst(rst),
        .ticks(ticks)
    );

    cmt_channel u_ch0 (
        .clk(clk),
        .rst(rst),
        .bus(ch0.chan)
    );

    cmt_channel u_ch1 (
        .clk(clk),
        .rst(rst),
        .bus(ch1.chan)
    );

    function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                               input logic [1:0] be);
        lane_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    // Every access takes exactly one wait state, so read data come from a register.
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign wr_go = avs_write && ack;
    assign rd_go = avs_read && ack;

    assign ch0.ticks = ticks;
    assign ch1.ticks = ticks;
    assign ch0.run = run[cmt_pkg::CMT_BIT_RUN_CH0];
    assign ch1.run = run[cmt_pkg::CMT_BIT_RUN_CH1];
    assign ch0.wr_counter = wr_go && (avs_address == cmt_pkg::CMT_IDX_CNT0);
    assign ch1.wr_counter = wr_go && (avs_address == cmt_pkg::CMT_IDX_CNT1);
    assign ch0.wr_constant = wr_go && (avs_address == cmt_pkg::CMT_IDX_CONST0);
    assign ch1.wr_constant = wr_go && (avs_address == cmt_pkg::CMT_IDX_CONST1);
    assign ch0.wr_csr = wr_go && (avs_address == cmt_pkg::CMT_IDX_CSR0) && avs_byteenable[0];
    assign ch1.wr_csr = wr_go && (avs_address == cmt_pkg::CMT_IDX_CSR1) && avs_byteenable[0];
    // The arming read is the one whose data the master takes. The flag may set between
    // loading the read data and taking them, so arming follows the flag in the data returned.
    assign ch0.rd_csr = rd_go && (avs_address == cmt_pkg::CMT_IDX_CSR0)
                        && readdata[cmt_pkg::CMT_BIT_MATCH_FLAG];
    assign ch1.rd_csr = rd_go && (avs_address == cmt_pkg::CMT_IDX_CSR1)
                        && readdata[cmt_pkg::CMT_BIT_MATCH_FLAG];

    always_comb begin
        ch0.wdata = avs_writedata[15:0];
        ch1.wdata = avs_writedata[15:0];
        if (avs_address == cmt_pkg::CMT_IDX_CNT0) begin
            ch0.wdata = lane_merge(ch0.counter, avs_writedata[15:0], avs_byteenable[1:0]);
        end else if (avs_address == cmt_pkg::CMT_IDX_CONST0) begin
            ch0.wdata = lane_merge(ch0.constant, avs_writedata[15:0], avs_byteenable[1:0]);
        end else if (avs_address == cmt_pkg::CMT_IDX_CSR0) begin
            ch0.wdata = lane_merge(ch0.csr, avs_writedata[15:0], avs_byteenable[1:0]);
        end
        if (avs_address == cmt_pkg::CMT_IDX_CNT1) begin
            ch1.wdata = lane_merge(ch1.counter, avs_writedata[15:0], avs_byteenable[1:0]);
        end else if (avs_address == cmt_pkg::CMT_IDX_CONST1) begin
            ch1.wdata = lane_merge(ch1.constant, avs_writedata[15:0], avs_byteenable[1:0]);
        end else if (avs_address == cmt_pkg::CMT_IDX_CSR1) begin
            ch1.wdata = lane_merge(ch1.csr, avs_writedata[15:0], avs_byteenable[1:0]);
        end
    end

    always_comb begin
        next_ack = (avs_read || avs_write) && !ack;
        next_readdata = readdata;
        next_run = run;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        if (avs_read && !ack) begin
            if (avs_address == cmt_pkg::CMT_IDX_START) begin
                next_readdata = {30'h00000000, run};
            end else if (avs_address == cmt_pkg::CMT_IDX_CSR0) begin
                next_readdata = {16'h0000, ch0.csr};
            end else if (avs_address == cmt_pkg::CMT_IDX_CNT0) begin
                next_readdata = {16'h0000, ch0.counter};
            end else if (avs_address == cmt_pkg::CMT_IDX_CONST0) begin
                next_readdata = {16'h0000, ch0.constant};
            end else if (avs_address == cmt_pkg::CMT_IDX_CSR1) begin
                next_readdata = {16'h0000, ch1.csr};
            end else if (avs_address == cmt_pkg::CMT_IDX_CNT1) begin
                next_readdata = {16'h0000, ch1.counter};
            end else if (avs_address == cmt_pkg::CMT_IDX_CONST1) begin
                next_readdata = {16'h0000, ch1.constant};
            end else if (avs_address == cmt_pkg::CMT_IDX_IRQ_STATUS) begin
                next_readdata = {30'h00000000, irq_status};
            end else if (avs_address == cmt_pkg::CMT_IDX_IRQ_MASK) begin
                next_readdata = {30'h00000000, irq_mask};
            end else begin
                next_readdata = 32'h00000000;
            end
        end
        if (wr_go && avs_byteenable[0]) begin
            if (avs_address == cmt_pkg::CMT_IDX_START) begin
                next_run = avs_writedata[1:0];
            end else if (avs_address == cmt_pkg::CMT_IDX_IRQ_MASK) begin
                next_irq_mask = avs_writedata[1:0];
            end else if (avs_address == cmt_pkg::CMT_IDX_IRQ_STATUS) begin
                next_irq_status = irq_status & ~avs_writedata[1:0];
            end
        end
        // A match in the cycle of a clearing write keeps its status bit.
        next_irq_status = next_irq_status | {ch1.match_event, ch0.match_event};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ack <= 1'b0;
            readdata <= 32'h00000000;
            run <= cmt_pkg::CMT_RST_RUN;
            irq_status <= cmt_pkg::CMT_RST_IRQ;
            irq_mask <= cmt_pkg::CMT_RST_IRQ;
        end else begin
            ack <= next_ack;
            readdata <= next_readdata;
            run <= next_run;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
        end
    end

    assign avs_readdata = readdata;
    assign match_interrupt_ch0 = ch0.match_interrupt;
    assign match_interrupt_ch1 = ch1.match_interrupt;
    assign irq = |(irq_status & irq_mask);
endmodule

// ===== design/cmt_pkg.sv
/*
 * Shared constants of the two-channel compare match timer: register
 * indices, field positions, reset values and prescaler ratios.
 * Assumes a word-addressed register bus whose address is the register index.
 */
package cmt_pkg;

    localparam int CMT_ADDR_W = 32;
    localparam int CMT_DATA_W = 16;
    localparam int CMT_CHANNELS = 2;

    // Register indices; the byte address is four times the index.
    localparam logic [31:0] CMT_IDX_START = 32'hFFFF83D0;
    localparam logic [31:0] CMT_IDX_CSR0 = 32'hFFFF83D2;
    localparam logic [31:0] CMT_IDX_CNT0 = 32'hFFFF83D4;
    localparam logic [31:0] CMT_IDX_CONST0 = 32'hFFFF83D6;
    localparam logic [31:0] CMT_IDX_CSR1 = 32'hFFFF83D8;
    localparam logic [31:0] CMT_IDX_CNT1 = 32'hFFFF83DA;
    localparam logic [31:0] CMT_IDX_CONST1 = 32'hFFFF83DC;
    localparam logic [31:0] CMT_IDX_IRQ_STATUS = 32'hFFFF83E0;
    localparam logic [31:0] CMT_IDX_IRQ_MASK = 32'hFFFF83E1;

    // Control/status field positions.
    localparam int CMT_BIT_MATCH_FLAG = 7;
    localparam int CMT_BIT_MATCH_IRQ_ENABLE = 6;
    localparam int CMT_BIT_PRESCALE_SEL_HI = 1;
    localparam int CMT_BIT_PRESCALE_SEL_LO = 0;

    // Start register field positions.
    localparam int CMT_BIT_RUN_CH0 = 0;
    localparam int CMT_BIT_RUN_CH1 = 1;

    // Reset values.
    localparam logic [15:0] CMT_RST_COUNTER = 16'h0000;
    localparam logic [15:0] CMT_RST_CONSTANT = 16'hFFFF;
    localparam logic [1:0] CMT_RST_PRESCALE_SEL = 2'h0;
    localparam logic [1:0] CMT_RST_RUN = 2'h0;
    localparam logic [1:0] CMT_RST_IRQ = 2'h0;

    // Prescaler: select n divides the clock by 2**(3 + 2*n).
    localparam int CMT_DIV_BASE_LOG2 = 3;
    localparam int CMT_DIV_STEP_LOG2 = 2;
    localparam int CMT_DIV_SELECTS = 4;
    localparam int CMT_DIV_W = CMT_DIV_BASE_LOG2 + CMT_DIV_STEP_LOG2 * (CMT_DIV_SELECTS - 1);

endpackage

// ===== design/cmt_chan_if.sv
/*
 * Carrier between the timer's register front end and one timer channel.
 * Assumes one clock; every strobe is a single-cycle pulse.
 */
`timescale 1ns/1ps
interface cmt_chan_if;
    logic [cmt_pkg::CMT_DIV_SELECTS-1:0] ticks;
    logic run;
    logic wr_counter;
    logic wr_constant;
    logic wr_csr;
    logic rd_csr;
    logic [15:0] wdata;
    logic [15:0] counter;
    logic [15:0] constant;
    logic [15:0] csr;
    logic match_event;
    logic match_interrupt;

    modport ctrl (
        output ticks, run, wr_counter, wr_constant, wr_csr, rd_csr, wdata,
        input counter, constant, csr, match_event, match_interrupt
    );
    modport chan (
        input ticks, run, wr_counter, wr_constant, wr_csr, rd_csr, wdata,
        output counter, constant, csr, match_event, match_interrupt
    );
endinterface

// ===== design/cmt_channel.sv
/*
 * One compare match channel: up counter, match constant and control/status.
 * Assumes write data already merged by byte lanes and strobes of one cycle.
 */
`timescale 1ns/1ps
module cmt_channel (
    input wire logic clk,
    input wire logic rst,
    cmt_chan_if.chan bus
);
    logic [15:0] up_counter, next_up_counter;
    logic [15:0] match_constant, next_match_constant;
    logic match_flag, next_match_flag;
    logic flag_seen, next_flag_seen;
    logic match_irq_enable, next_match_irq_enable;
    logic [1:0] prescale_sel, next_prescale_sel;
    logic tick;
    logic hit;

    assign tick = bus.ticks[prescale_sel];
    assign hit = bus.run && tick && (up_counter == match_constant);

    always_comb begin
        next_up_counter = up_counter;
        next_match_constant = match_constant;
        next_match_flag = match_flag;
        next_flag_seen = flag_seen;
        next_match_irq_enable = match_irq_enable;
        next_prescale_sel = prescale_sel;
        if (bus.run && tick) begin
            next_up_counter = hit ? 16'h0000 : up_counter + 16'h0001;
        end
        // A software write to the counter wins over the count in the same cycle.
        if (bus.wr_counter) begin
            next_up_counter = bus.wdata;
        end
        if (bus.wr_constant) begin
            next_match_constant = bus.wdata;
        end
        if (bus.rd_csr && match_flag) begin
            next_flag_seen = 1'b1;
        end
        if (bus.wr_csr) begin
            next_match_irq_enable = bus.wdata[cmt_pkg::CMT_BIT_MATCH_IRQ_ENABLE];
            next_prescale_sel = bus.wdata[cmt_pkg::CMT_BIT_PRESCALE_SEL_HI:
                                          cmt_pkg::CMT_BIT_PRESCALE_SEL_LO];
            next_flag_seen = 1'b0;
            // A one written to the flag is ignored; a zero clears only after a read of one.
            if (!bus.wdata[cmt_pkg::CMT_BIT_MATCH_FLAG] && flag_seen) begin
                next_match_flag = 1'b0;
            end
        end
        // A match in the clearing cycle is kept.
        if (hit) begin
            next_match_flag = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            up_counter <= cmt_pkg::CMT_RST_COUNTER;
            match_constant <= cmt_pkg::CMT_RST_CONSTANT;
            match_flag <= 1'b0;
            flag_seen <= 1'b0;
            match_irq_enable <= 1'b0;
            prescale_sel <= cmt_pkg::CMT_RST_PRESCALE_SEL;
        end else begin
            up_counter <= next_up_counter;
            match_constant <= next_match_constant;
            match_flag <= next_match_flag;
            flag_seen <= next_flag_seen;
            match_irq_enable <= next_match_irq_enable;
            prescale_sel <= next_prescale_sel;
        end
    end

    assign bus.counter = up_counter;
    assign bus.constant = match_constant;
    assign bus.csr = {8'h00, match_flag, match_irq_enable, 4'h0, prescale_sel};
    assign bus.match_event = hit;
    assign bus.match_interrupt = match_flag && match_irq_enable;
endmodule

// ===== design/cmt_prescaler.sv
/*
 * Free-running clock divider giving one-cycle enable pulses at the four
 * counter rates. Assumes the single system clock and synchronous reset.
 */
`timescale 1ns/1ps
module cmt_prescaler (
    input wire logic clk,
    input wire logic rst,
    output logic [cmt_pkg::CMT_DIV_SELECTS-1:0] ticks
);
    logic [cmt_pkg::CMT_DIV_W-1:0] div, next_div;

    always_comb begin
        next_div = div + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div <= '0;
        end else begin
            div <= next_div;
        end
    end

    // Pulse n fires when the low 3 + 2*n bits are all ones.
    for (genvar i = 0; i < cmt_pkg::CMT_DIV_SELECTS; i++) begin : g_tick
        localparam int W = cmt_pkg::CMT_DIV_BASE_LOG2 + cmt_pkg::CMT_DIV_STEP_LOG2 * i;
        assign ticks[i] = &div[W-1:0];
    end
endmodule

// ===== dv/cmt_timer_sva.sv
/* Port-level checker of the compare match timer.
   Assumes a bus master that holds each request until waitrequest is low. */
`timescale 1ns/1ps
module cmt_timer_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic match_interrupt_ch0,
    input wire logic match_interrupt_ch1,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire req = avs_read || avs_write;
    wire taken = req && !avs_waitrequest;
    wait_first_a: assert property ($rose(req) |-> avs_waitrequest)
        else $error("no wait state on a new request");
    wait_once_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait state");
    idle_ready_a: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest raised while idle");
    upper_zero_a: assert property (taken && avs_read |-> avs_readdata[31:16] == 16'h0000)
        else $error("read data above bit 15 not zero");
    unmapped_zero_a: assert property (taken && avs_read && avs_address == 32'hFFFF83D1
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    irq_reset_a: assert property ($past(rst) |-> !irq && !match_interrupt_ch0 && !match_interrupt_ch1)
        else $error("interrupt high after reset");
    flag_clear0_a: assert property ($fell(match_interrupt_ch0)
        |-> $past(taken && avs_write && avs_address == cmt_pkg::CMT_IDX_CSR0))
        else $error("channel 0 request fell without a control write");
    flag_clear1_a: assert property ($fell(match_interrupt_ch1)
        |-> $past(taken && avs_write && avs_address == cmt_pkg::CMT_IDX_CSR1))
        else $error("channel 1 request fell without a control write");
    irq_fall_a: assert property ($fell(irq) |-> $past(taken && avs_write))
        else $error("irq fell without a write");
    cover property ($rose(irq));
    cover property ($rose(match_interrupt_ch1));
    cover property ($fell(match_interrupt_ch0));
endmodule
bind cmt_timer cmt_timer_sva i_sva (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .match_interrupt_ch0(match_interrupt_ch0),
    .match_interrupt_ch1(match_interrupt_ch1), .irq(irq));

// ===== dv/tb_cmt_timer.sv
/* Self-checking bench of the compare match timer over its Avalon-MM port.
   Assumes the design answers each request after a wait state. */
`timescale 1ns/1ps
module tb_cmt_timer;
    logic clk;
    logic rst;
    logic [31:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic match_interrupt_ch0;
    logic match_interrupt_ch1;
    logic irq;
    int miscompares = 0;
    int compares = 0;

    cmt_timer i_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .match_interrupt_ch0(match_interrupt_ch0), .match_interrupt_ch1(match_interrupt_ch1),
        .irq(irq));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // The request is held until waitrequest is sampled low, for at most 20 clock cycles.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        check("bus answer", 32'(n < 20), 32'h1);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] v;
        bus(1'b1, a, wd, v);
    endtask

    task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        check(what, v, exp);
    endtask

    task automatic wait_req(input int ch);
        int n;
        n = 0;
        while ((ch == 0 ? match_interrupt_ch0 : match_interrupt_ch1) !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic t_reset();
        rdchk("cnt0", cmt_pkg::CMT_IDX_CNT0, 32'h0);
        rdchk("const0", cmt_pkg::CMT_IDX_CONST0, 32'hFFFF);
        rdchk("csr0", cmt_pkg::CMT_IDX_CSR0, 32'h0);
        rdchk("const1", cmt_pkg::CMT_IDX_CONST1, 32'hFFFF);
        rdchk("start", cmt_pkg::CMT_IDX_START, 32'h0);
        rdchk("unmapped", 32'hFFFF83D1, 32'h0);
        wr(cmt_pkg::CMT_IDX_CONST1, 32'h1234);
        wr(cmt_pkg::CMT_IDX_CNT1, 32'h00A5);
        rdchk("const1 rw", cmt_pkg::CMT_IDX_CONST1, 32'h1234);
        rdchk("cnt1 rw", cmt_pkg::CMT_IDX_CNT1, 32'h00A5);
        // Byte lanes: each write changes only its enabled byte; the control needs lane 0.
        avs_byteenable <= 4'h1;
        wr(cmt_pkg::CMT_IDX_CNT1, 32'h5A5A);
        avs_byteenable <= 4'h2;
        wr(cmt_pkg::CMT_IDX_CNT1, 32'h3C3C);
        wr(cmt_pkg::CMT_IDX_CSR1, 32'h0003);
        avs_byteenable <= 4'h3;
        rdchk("cnt1 lanes", cmt_pkg::CMT_IDX_CNT1, 32'h3C5A);
        rdchk("csr1 lane", cmt_pkg::CMT_IDX_CSR1, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_match();
        logic [31:0] v;
        wr(cmt_pkg::CMT_IDX_CONST0, 32'h3);
        wr(cmt_pkg::CMT_IDX_IRQ_MASK, 32'h1);
        wr(cmt_pkg::CMT_IDX_CSR0, 32'h40);
        wr(cmt_pkg::CMT_IDX_START, 32'h1);
        wait_req(0);
        check("ch0 request", match_interrupt_ch0, 1'b1);
        check("irq", irq, 1'b1);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, cmt_pkg::CMT_IDX_CNT0, 32'h0, v);
            check("cnt0 bound", 32'(v <= 32'h3), 32'h1);
        end
        wr(cmt_pkg::CMT_IDX_START, 32'h0);
        wr(cmt_pkg::CMT_IDX_CSR0, 32'h80);
        @(negedge clk);
        check("ch0 disabled", match_interrupt_ch0, 1'b0);
        wr(cmt_pkg::CMT_IDX_CSR0, 32'h40);
        rdchk("csr0 unread", cmt_pkg::CMT_IDX_CSR0, 32'hC0);
        wr(cmt_pkg::CMT_IDX_CSR0, 32'hC0);
        rdchk("csr0 one", cmt_pkg::CMT_IDX_CSR0, 32'hC0);
        wr(cmt_pkg::CMT_IDX_CSR0, 32'h40);
        rdchk("csr0 clear", cmt_pkg::CMT_IDX_CSR0, 32'h40);
        check("irq sticky", irq, 1'b1);
        wr(cmt_pkg::CMT_IDX_IRQ_MASK, 32'h0);
        @(negedge clk);
        check("irq masked", irq, 1'b0);
        wr(cmt_pkg::CMT_IDX_IRQ_MASK, 32'h1);
        wr(cmt_pkg::CMT_IDX_IRQ_STATUS, 32'h1);
        @(negedge clk);
        check("irq cleared", irq, 1'b0);
        $display("test match done");
    endtask

    task automatic t_rate();
        logic [31:0] a;
        logic [31:0] b;
        for (int s = 0; s < 5; s++) begin
            wr(cmt_pkg::CMT_IDX_START, 32'h0);
            wr(cmt_pkg::CMT_IDX_CNT1, 32'h0);
            wr(cmt_pkg::CMT_IDX_CSR1, 32'(s % 4));
            wr(cmt_pkg::CMT_IDX_START, s < 4 ? 32'h2 : 32'h1);
            bus(1'b0, cmt_pkg::CMT_IDX_CNT1, 32'h0, a);
            // Two reads exactly sixteen divided periods apart see sixteen ticks, or none in the last pass with ch1 halted.
            repeat ((16 << (2 * (s % 4) + 3)) - 3) @(posedge clk);
            bus(1'b0, cmt_pkg::CMT_IDX_CNT1, 32'h0, b);
            check("cnt1 ticks", b - a, s < 4 ? 32'h10 : 32'h0);
        end
        wr(cmt_pkg::CMT_IDX_CONST1, 32'h1);
        wr(cmt_pkg::CMT_IDX_CSR1, 32'h40);
        wr(cmt_pkg::CMT_IDX_START, 32'h2);
        // Channel 0 ran in the last rate pass and matched; drop its status so only ch1 is left.
        wr(cmt_pkg::CMT_IDX_IRQ_STATUS, 32'h1);
        wait_req(1);
        check("ch1 request", match_interrupt_ch1, 1'b1);
        wr(cmt_pkg::CMT_IDX_START, 32'h0);
        rdchk("csr1 flag", cmt_pkg::CMT_IDX_CSR1, 32'hC0);
        wr(cmt_pkg::CMT_IDX_CSR1, 32'h0);
        rdchk("csr1 clear", cmt_pkg::CMT_IDX_CSR1, 32'h0);
        check("irq unmasked only", irq, 1'b0);
        rdchk("irq status", cmt_pkg::CMT_IDX_IRQ_STATUS, 32'h2);
        $display("test rate done");
    endtask

    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        avs_address = 32'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h3;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_match();
        t_rate();
        end_sim();
    end

    initial begin
        #400000;
        miscompares++;
        end_sim();
    end
endmodule
